// ===== hdl/prc_pkg.sv
// Purpose: shared constants and types for the parameter request channel
// Assumes: 8-byte channel exchanged once per cyclic frame strobe
// Notes: byte 0 is the high byte of the identifier word
package prc_pkg;
    localparam int PRC_CODE_HI = 15;
    localparam int PRC_CODE_LO = 12;
    localparam int PRC_TOGGLE_BIT = 11;
    localparam int PRC_PNUM_HI = 10;
    localparam int PRC_PNUM_LO = 0;
    localparam int PRC_PNUM_W = 11;

    typedef logic [3:0] prc_code_t;
    typedef logic [10:0] prc_pnum_t;
    typedef logic [3:0] prc_pkind_t;

    // request codes
    localparam prc_code_t PRC_RQ_NONE = 4'h0;
    localparam prc_code_t PRC_RQ_READ = 4'h1;
    localparam prc_code_t PRC_RQ_WR_W = 4'h2;
    localparam prc_code_t PRC_RQ_WR_D = 4'h3;
    localparam prc_code_t PRC_RQ_RD_ARR = 4'h6;
    localparam prc_code_t PRC_RQ_WR_AW = 4'h7;
    localparam prc_code_t PRC_RQ_WR_AD = 4'h8;
    localparam prc_code_t PRC_RQ_ARR_CNT = 4'h9;

    // response codes
    localparam prc_code_t PRC_RS_NONE = 4'h0;
    localparam prc_code_t PRC_RS_WORD = 4'h1;
    localparam prc_code_t PRC_RS_DWORD = 4'h2;
    localparam prc_code_t PRC_RS_ARR_W = 4'h4;
    localparam prc_code_t PRC_RS_ARR_D = 4'h5;
    localparam prc_code_t PRC_RS_ARR_CNT = 4'h6;
    localparam prc_code_t PRC_RS_ERROR = 4'h7;

    // error numbers carried in the value field
    localparam logic [31:0] PRC_ERR_PNUM = 32'h0000_0000;
    localparam logic [31:0] PRC_ERR_RDONLY = 32'h0000_0001;
    localparam logic [31:0] PRC_ERR_LIMIT = 32'h0000_0002;
    localparam logic [31:0] PRC_ERR_SUBIDX = 32'h0000_0003;
    localparam logic [31:0] PRC_ERR_NOARR = 32'h0000_0004;
    localparam logic [31:0] PRC_ERR_DTYPE = 32'h0000_0005;
    localparam logic [31:0] PRC_ERR_RESET = 32'h0000_0006;
    localparam logic [31:0] PRC_ERR_STATE = 32'h0000_0011;
    localparam logic [31:0] PRC_ERR_OTHER = 32'h0000_0012;

    // parameter kinds reported by the user-side lookup
    localparam prc_pkind_t PRC_PK_NONE = 4'h0;
    localparam prc_pkind_t PRC_PK_WORD = 4'h1;
    localparam prc_pkind_t PRC_PK_DWORD = 4'h2;
    localparam prc_pkind_t PRC_PK_ARR_W = 4'h3;
    localparam prc_pkind_t PRC_PK_ARR_D = 4'h4;

    localparam logic [15:0] PRC_IDENT_RESET = 16'h0000;
    localparam logic [15:0] PRC_SUB_RESET = 16'h0000;
    localparam logic [31:0] PRC_VAL_RESET = 32'h0000_0000;

    function automatic logic [15:0] prc_ident(input prc_code_t code, input prc_pnum_t pnum);
        prc_ident = {code, 1'b0, pnum};
    endfunction

    function automatic prc_code_t prc_code_of(input logic [15:0] ident);
        prc_code_of = ident[PRC_CODE_HI:PRC_CODE_LO];
    endfunction

    function automatic prc_pnum_t prc_pnum_of(input logic [15:0] ident);
        prc_pnum_of = ident[PRC_PNUM_HI:PRC_PNUM_LO];
    endfunction
endpackage

// ===== hdl/prc_if.sv
// Purpose: cyclic parameter channel between controller and device
// Assumes: one clock; fields qualified by the frame strobes
// Notes: request flows controller to device, response back
`timescale 1ns/1ps
interface prc_if;
    logic rq_frame;
    logic [15:0] rq_ident;
    logic [15:0] rq_sub;
    logic [31:0] rq_value;
    logic rs_frame;
    logic [15:0] rs_ident;
    logic [15:0] rs_sub;
    logic [31:0] rs_value;

    modport ctrl (
        output rq_frame,
        output rq_ident,
        output rq_sub,
        output rq_value,
        input rs_frame,
        input rs_ident,
        input rs_sub,
        input rs_value
    );

    modport dev (
        input rq_frame,
        input rq_ident,
        input rq_sub,
        input rq_value,
        output rs_frame,
        output rs_ident,
        output rs_sub,
        output rs_value
    );
endinterface

// ===== hdl/prc_device.sv
// Purpose: device end, decodes requests and holds the answer
// Assumes: parameter store on the user side answers in one cycle
// Notes: a request is taken only when it differs from the last one
`timescale 1ns/1ps
// Contract
// - controller repeats request until answered
// - response held until a different request
// - code 0 answered with 0, rearms
// - only one request processed at once
// - identifier word in bytes 0 and 1
// - code, toggle bit, parameter number order
// - toggle bit ignored, driven zero
// - request code set and meaning
// - success answer mapping, 7 on failure
// - response code set and meaning
// - subindex carried for array parameters
// - error code placed in value field
// - error code numbering
// - write answered as read, echoing fields
module prc_device (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic CE,
    prc_if.dev LINK,
    output logic PAR_REQ,
    output logic PAR_WRITE,
    output prc_pkg::prc_pnum_t PAR_NUM,
    output logic [15:0] PAR_SUB,
    output logic [31:0] PAR_WDATA,
    input wire prc_pkg::prc_pkind_t PAR_KIND,
    input wire logic [15:0] PAR_COUNT,
    input wire logic [31:0] PAR_RDATA,
    input wire logic PAR_OK,
    input wire logic [31:0] PAR_ERR,
    output logic BUSY
);
    import prc_pkg::*;

    typedef enum logic [2:0] {
        IDLE = 3'b001,
        LOOK = 3'b010,
        DONE = 3'b100
    } prc_state_e;

    prc_state_e state_reg, state_next;
    logic [15:0] last_ident_reg;
    logic [15:0] last_sub_reg;
    logic [31:0] last_val_reg;
    logic seen_reg;
    logic [15:0] rs_ident_reg, rs_sub_reg;
    logic [31:0] rs_val_reg;
    logic rs_frame_reg;

    // toggle bit masked out so it never makes a request look new
    wire [15:0] rq_masked = LINK.rq_ident & 16'hF7FF;
    wire prc_code_t rq_code = prc_code_of(rq_masked);
    wire prc_pnum_t rq_pnum = prc_pnum_of(rq_masked);
    // a repeat of the last taken request is not new work
    wire same_req = seen_reg
        && rq_masked == last_ident_reg
        && LINK.rq_sub == last_sub_reg
        && LINK.rq_value == last_val_reg;
    wire is_new = LINK.rq_frame && !same_req;
    // a differing request while busy is dropped; the controller resends it
    wire take = is_new && state_reg == IDLE;

    wire prc_code_t cur_code = prc_code_of(last_ident_reg);
    wire prc_pnum_t cur_pnum = prc_pnum_of(last_ident_reg);
    wire is_read = cur_code == PRC_RQ_READ;
    wire is_arr_rd = cur_code == PRC_RQ_RD_ARR;
    wire is_cnt = cur_code == PRC_RQ_ARR_CNT;
    wire is_arr_wr = cur_code == PRC_RQ_WR_AW
        || cur_code == PRC_RQ_WR_AD;
    wire is_wr = cur_code == PRC_RQ_WR_W
        || cur_code == PRC_RQ_WR_D
        || is_arr_wr;
    wire is_arr_kind = PAR_KIND == PRC_PK_ARR_W
        || PAR_KIND == PRC_PK_ARR_D;
    wire valid_code = is_read
        || is_arr_rd
        || is_cnt
        || is_wr;

    // width the write asks for must match the parameter's kind
    wire wr_kind_ok = (cur_code == PRC_RQ_WR_W && PAR_KIND == PRC_PK_WORD)
        || (cur_code == PRC_RQ_WR_D && PAR_KIND == PRC_PK_DWORD)
        || (cur_code == PRC_RQ_WR_AW && PAR_KIND == PRC_PK_ARR_W)
        || (cur_code == PRC_RQ_WR_AD && PAR_KIND == PRC_PK_ARR_D);
    wire arr_req = is_arr_rd
        || is_cnt
        || is_arr_wr;
    // count requests carry no element, so only element accesses are range checked
    wire sub_bad = (is_arr_rd || is_arr_wr)
        && is_arr_kind
        && last_sub_reg >= PAR_COUNT;

    // failure causes, listed in priority order
    wire no_param = PAR_KIND == PRC_PK_NONE;
    wire no_array = arr_req && !is_arr_kind;
    wire bad_width = is_wr && !wr_kind_ok;
    wire plain_on_arr = is_read && is_arr_kind;
    wire [31:0] err_code = no_param ? PRC_ERR_PNUM :
        !valid_code ? PRC_ERR_OTHER :
        no_array ? PRC_ERR_NOARR :
        sub_bad ? PRC_ERR_SUBIDX :
        bad_width ? PRC_ERR_DTYPE :
        plain_on_arr ? PRC_ERR_SUBIDX :
        PAR_ERR;
    wire pre_fail = no_param
        || !valid_code
        || no_array
        || sub_bad
        || bad_width
        || plain_on_arr;
    // user refusal comes with the lookup, after the commit strobe is decided
    wire fail = pre_fail || !PAR_OK;

    // data-type answer, shared by reads and successful writes
    wire prc_code_t kind_code = PAR_KIND == PRC_PK_WORD ? PRC_RS_WORD :
        PAR_KIND == PRC_PK_DWORD ? PRC_RS_DWORD :
        PAR_KIND == PRC_PK_ARR_W ? PRC_RS_ARR_W :
        PRC_RS_ARR_D;
    wire prc_code_t ok_code = is_cnt
        ? PRC_RS_ARR_CNT
        : kind_code;
    wire [31:0] ok_val = is_cnt ? {16'h0000, PAR_COUNT} :
        is_wr ? last_val_reg :
        PAR_RDATA;
    wire prc_code_t ans_code = fail ? PRC_RS_ERROR : ok_code;
    wire [15:0] ans_ident = prc_ident(ans_code, cur_pnum);
    wire [31:0] ans_val = fail
        ? err_code
        : ok_val;

    // lookup strobes decode from the state, so they last exactly one CE-enabled cycle
    assign PAR_REQ = state_reg == LOOK;
    assign PAR_WRITE = state_reg == LOOK && is_wr && !pre_fail;
    assign PAR_NUM = cur_pnum;
    assign PAR_SUB = last_sub_reg;
    assign PAR_WDATA = last_val_reg;
    assign BUSY = state_reg != IDLE;

    // code 0 needs no lookup, so IDLE stays put for it
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            IDLE: begin
                if (take && rq_code != PRC_RQ_NONE) begin
                    state_next = LOOK;
                end
            end
            LOOK: state_next = DONE;
            DONE: state_next = IDLE;
            default: state_next = IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state_reg <= IDLE;
            seen_reg <= 1'b0;
            last_ident_reg <= PRC_IDENT_RESET;
            last_sub_reg <= PRC_SUB_RESET;
            last_val_reg <= PRC_VAL_RESET;
        end else if (CE) begin
            state_reg <= state_next;
            // identical repeats leave the latched copy alone
            if (take) begin
                seen_reg <= 1'b1;
                last_ident_reg <= rq_masked;
                last_sub_reg <= LINK.rq_sub;
                last_val_reg <= LINK.rq_value;
            end
        end
    end

    // answer fields change only after a taken request; the frame flag is rewritten every CE cycle
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            rs_ident_reg <= PRC_IDENT_RESET;
            rs_sub_reg <= PRC_SUB_RESET;
            rs_val_reg <= PRC_VAL_RESET;
            rs_frame_reg <= 1'b0;
        end else if (CE) begin
            // frame flag is only a delayed echo of the request frame
            rs_frame_reg <= LINK.rq_frame;
            if (take && rq_code == PRC_RQ_NONE) begin
                rs_ident_reg <= prc_ident(PRC_RS_NONE, rq_pnum);
                rs_sub_reg <= LINK.rq_sub;
                rs_val_reg <= PRC_VAL_RESET;
            end else if (state_reg == LOOK) begin
                rs_ident_reg <= ans_ident;
                rs_sub_reg <= last_sub_reg;
                rs_val_reg <= ans_val;
            end
        end
    end

    // answer stands until the next taken request replaces it
    assign LINK.rs_frame = rs_frame_reg;
    assign LINK.rs_ident = rs_ident_reg;
    assign LINK.rs_sub = rs_sub_reg;
    assign LINK.rs_value = rs_val_reg;
endmodule

// ===== hdl/prc_ctrl.sv
// Purpose: controller end, issues one request and repeats it
// Assumes: user pulses CMD_GO only while CMD_READY is high
// Notes: rearms through code 0 before the next request
`timescale 1ns/1ps
module prc_ctrl (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic CE,
    prc_if.ctrl LINK,
    input wire logic CMD_GO,
    input wire prc_pkg::prc_code_t CMD_CODE,
    input wire prc_pkg::prc_pnum_t CMD_PNUM,
    input wire logic [15:0] CMD_SUB,
    input wire logic [31:0] CMD_VALUE,
    output logic CMD_READY,
    output logic RSP_VALID,
    output prc_pkg::prc_code_t RSP_CODE,
    output logic [15:0] RSP_SUB,
    output logic [31:0] RSP_VALUE
);
    import prc_pkg::*;

    typedef enum logic [2:0] {
        C_IDLE = 3'b001,
        C_WAIT = 3'b010,
        C_CLEAR = 3'b100
    } prc_cstate_e;

    prc_cstate_e state_reg;
    logic [15:0] id_reg, sub_reg;
    logic [31:0] val_reg;
    logic rsp_valid_reg;
    prc_code_t rsp_code_reg;
    logic [15:0] rsp_sub_reg;
    logic [31:0] rsp_val_reg;

    wire prc_code_t got = prc_code_of(LINK.rs_ident);
    wire answered = LINK.rs_frame && got != PRC_RS_NONE
        && prc_pnum_of(LINK.rs_ident) == prc_pnum_of(id_reg);
    wire cleared = LINK.rs_frame && got == PRC_RS_NONE;

    assign CMD_READY = state_reg == C_IDLE;
    assign LINK.rq_frame = CE; // request resent each cycle
    assign LINK.rq_ident = id_reg;
    assign LINK.rq_sub = sub_reg;
    assign LINK.rq_value = val_reg;
    assign RSP_VALID = rsp_valid_reg;
    assign RSP_CODE = rsp_code_reg;
    assign RSP_SUB = rsp_sub_reg;
    assign RSP_VALUE = rsp_val_reg;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state_reg <= C_IDLE;
            id_reg <= PRC_IDENT_RESET;
            sub_reg <= PRC_SUB_RESET;
            val_reg <= PRC_VAL_RESET;
            rsp_valid_reg <= 1'b0;
            rsp_code_reg <= PRC_RS_NONE;
            rsp_sub_reg <= PRC_SUB_RESET;
            rsp_val_reg <= PRC_VAL_RESET;
        end else if (CE) begin
            rsp_valid_reg <= 1'b0;
            case (state_reg)
                C_IDLE: begin
                    if (CMD_GO && CMD_CODE != PRC_RQ_NONE) begin
                        id_reg <= prc_ident(CMD_CODE, CMD_PNUM);
                        sub_reg <= CMD_SUB;
                        val_reg <= CMD_VALUE;
                        state_reg <= C_WAIT;
                    end
                end
                C_WAIT: begin
                    if (answered) begin
                        rsp_valid_reg <= 1'b1;
                        rsp_code_reg <= got;
                        rsp_sub_reg <= LINK.rs_sub;
                        rsp_val_reg <= LINK.rs_value;
                        id_reg <= prc_ident(PRC_RQ_NONE, prc_pnum_of(id_reg));
                        state_reg <= C_CLEAR;
                    end
                end
                C_CLEAR: begin
                    if (cleared) begin
                        state_reg <= C_IDLE;
                    end
                end
                default: state_reg <= C_IDLE;
            endcase
        end
    end
endmodule

// ===== tb/prc_monitor.sv
// Purpose: watches the parameter channel between both ends
// Assumes: one clock, synchronous active-high reset
// Notes: answer delay checked as a short range, not an exact cycle
`timescale 1ns/1ps
module prc_monitor (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic rq_frame,
    input wire logic [15:0] rq_ident,
    input wire logic [15:0] rq_sub,
    input wire logic [31:0] rq_value,
    input wire logic [15:0] rs_ident,
    input wire logic [15:0] rs_sub,
    input wire logic [31:0] rs_value
);
    default clocking @(posedge REF_CLK);
    endclocking
    default disable iff (RST);
    property p_toggle;
        rq_ident[11] == 1'b0 && rs_ident[11] == 1'b0;
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle bit set");
    property p_repeat;
        $changed(rq_ident) && rq_ident[15:12] != 4'h0 |=> $stable(rq_ident) [*2];
    endproperty
    a_repeat: assert property (p_repeat) else $error("request dropped early");
    property p_hold;
        ($stable(rq_ident) && $stable(rq_sub) && $stable(rq_value)) [*4] |=> $stable(rs_ident) && $stable(rs_value);
    endproperty
    a_hold: assert property (p_hold) else $error("response moved");
    property p_zero;
        rq_frame && $changed(rq_ident) && rq_ident[15:12] == 4'h0 |-> ##[1:3] rs_ident[15:12] == 4'h0;
    endproperty
    a_zero: assert property (p_zero) else $error("no zero answer");
    property p_wr_word;
        $changed(rq_ident) && rq_ident[15:12] == 4'h2 |-> ##[1:3] rs_ident[15:12] inside {4'h1, 4'h7};
    endproperty
    a_wr_word: assert property (p_wr_word) else $error("bad word write answer");
    property p_arr_rd;
        $changed(rq_ident) && rq_ident[15:12] == 4'h6 |-> ##[1:3] rs_ident[15:12] inside {4'h4, 4'h5, 4'h7};
    endproperty
    a_arr_rd: assert property (p_arr_rd) else $error("bad array read answer");
    property p_echo;
        $changed(rs_ident) && rs_ident[15:12] != 4'h0 && rs_ident[15:12] != 4'h7
            |-> rs_ident[10:0] == rq_ident[10:0] && rs_sub == rq_sub;
    endproperty
    a_echo: assert property (p_echo) else $error("number or index not echoed");
    property p_wr_echo;
        $changed(rs_ident) && rs_ident[15:12] inside {4'h1, 4'h2, 4'h4, 4'h5}
            && rq_ident[15:12] inside {4'h2, 4'h3, 4'h7, 4'h8} |-> rs_value == rq_value;
    endproperty
    a_wr_echo: assert property (p_wr_echo) else $error("write value not echoed");
    property p_err;
        rs_ident[15:12] == 4'h7 |-> rs_value <= 32'h6 || rs_value == 32'h11 || rs_value == 32'h12;
    endproperty
    a_err: assert property (p_err) else $error("undefined error number");
endmodule

// ===== tb/test_parameter_request_channel.sv
// Purpose: runs both channel ends back to back through every request kind
// Assumes: CE held high except in the freeze test, user lookup answered by the bench
// Notes: lookup inputs change only between commands, par_kind and par_rdata together with a new one
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (a), (b)); end end
module test_parameter_request_channel;
    import prc_pkg::*;
    logic ref_clk;
    logic rst;
    logic cmd_go;
    prc_code_t cmd_code;
    prc_pnum_t cmd_pnum;
    logic [15:0] cmd_sub;
    logic [31:0] cmd_value;
    logic cmd_ready;
    logic rsp_valid;
    prc_code_t rsp_code;
    logic [15:0] rsp_sub;
    logic [31:0] rsp_value;
    logic par_write;
    logic [31:0] par_wdata;
    prc_pkind_t par_kind;
    logic [15:0] par_count;
    logic [31:0] par_rdata;
    logic par_ok;
    logic [31:0] par_err;
    logic [31:0] wr_data;
    logic ce;
    logic par_req;
    logic busy;
    prc_pnum_t par_num;
    logic [15:0] par_sub;
    prc_pnum_t req_num;
    logic [15:0] req_sub;
    int wr_seen = 0;
    int fail_count = 0;
    int tests_run = 0;
    prc_if prc_if_i ();
    prc_ctrl prc_ctrl_i (.REF_CLK(ref_clk), .RST(rst), .CE(ce), .LINK(prc_if_i), .CMD_GO(cmd_go),
        .CMD_CODE(cmd_code), .CMD_PNUM(cmd_pnum), .CMD_SUB(cmd_sub), .CMD_VALUE(cmd_value), .CMD_READY(cmd_ready),
        .RSP_VALID(rsp_valid), .RSP_CODE(rsp_code), .RSP_SUB(rsp_sub), .RSP_VALUE(rsp_value));
    prc_device prc_device_i (.REF_CLK(ref_clk), .RST(rst), .CE(ce), .LINK(prc_if_i), .PAR_REQ(par_req),
        .PAR_WRITE(par_write), .PAR_NUM(par_num), .PAR_SUB(par_sub), .PAR_WDATA(par_wdata), .PAR_KIND(par_kind),
        .PAR_COUNT(par_count), .PAR_RDATA(par_rdata), .PAR_OK(par_ok), .PAR_ERR(par_err), .BUSY(busy));
    prc_monitor prc_monitor_i (.REF_CLK(ref_clk), .RST(rst), .rq_frame(prc_if_i.rq_frame),
        .rq_ident(prc_if_i.rq_ident), .rq_sub(prc_if_i.rq_sub), .rq_value(prc_if_i.rq_value),
        .rs_ident(prc_if_i.rs_ident), .rs_sub(prc_if_i.rs_sub), .rs_value(prc_if_i.rs_value));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // commits seen at the user side, counted so refused writes show up
    always @(posedge ref_clk) begin
        if (par_write === 1'b1) begin
            wr_seen <= wr_seen + 1;
            wr_data <= par_wdata;
        end
        if (par_req === 1'b1) begin
            req_num <= par_num;
            req_sub <= par_sub;
        end
    end
    task automatic results;
        if (fail_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic issue(input prc_code_t c, input prc_pnum_t n, input logic [15:0] s, input logic [31:0] v,
            input prc_pkind_t k, input logic [31:0] rd, input prc_code_t ec, input logic [31:0] ev);
        int i;
        @(posedge ref_clk);
        cmd_go <= 1'b1;
        cmd_code <= c;
        cmd_pnum <= n;
        cmd_sub <= s;
        cmd_value <= v;
        par_kind <= k;
        par_rdata <= rd;
        @(posedge ref_clk);
        cmd_go <= 1'b0;
        // sampled 1 ns late so the edge's own updates have landed
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            #1;
            if (rsp_valid === 1'b1) break;
        end
        `CHK(rsp_valid, 1'b1)
        `CHK(rsp_code, ec)
        `CHK(rsp_value, ev)
        if (ec != 4'h7) `CHK(rsp_sub, s)
        `CHK(req_num, n)
        `CHK(req_sub, s)
        for (i = 0; i < 20 && cmd_ready !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        `CHK(cmd_ready, 1'b1)
        `CHK(busy, 1'b0)
    endtask
    task automatic t_freeze;
        logic [31:0] v0;
        v0 = rsp_value;
        @(posedge ref_clk);
        ce <= 1'b0;
        cmd_go <= 1'b1;
        cmd_code <= PRC_RQ_READ;
        cmd_pnum <= 11'h6;
        repeat (5) @(posedge ref_clk);
        #1;
        `CHK(cmd_ready, 1'b1)
        `CHK(busy, 1'b0)
        `CHK(rsp_value, v0)
        @(posedge ref_clk);
        ce <= 1'b1;
        cmd_go <= 1'b0;
    endtask
    task automatic t_reads;
        issue(4'h1, 11'h5, 16'h0, 32'h0, 4'h1, 32'h1234, 4'h1, 32'h1234);
        issue(4'h1, 11'h5, 16'h0, 32'h0, 4'h1, 32'h5678, 4'h1, 32'h5678);
        issue(4'h1, 11'h7FF, 16'h0, 32'h0, 4'h2, 32'hDEAD_BEEF, 4'h2, 32'hDEAD_BEEF);
    endtask
    task automatic t_writes;
        int n0;
        n0 = wr_seen;
        issue(4'h2, 11'h10, 16'h0, 32'hBEEF, 4'h1, 32'h0, 4'h1, 32'hBEEF);
        `CHK(wr_data, 32'hBEEF)
        issue(4'h3, 11'h11, 16'h0, 32'h1234_5678, 4'h2, 32'h0, 4'h2, 32'h1234_5678);
        issue(4'h7, 11'h12, 16'h3, 32'hAA, 4'h3, 32'h0, 4'h4, 32'hAA);
        issue(4'h8, 11'h13, 16'h1, 32'hCAFE_F00D, 4'h4, 32'h0, 4'h5, 32'hCAFE_F00D);
        `CHK(wr_data, 32'hCAFE_F00D)
        `CHK(wr_seen - n0, 4)
    endtask
    task automatic t_arrays;
        issue(4'h6, 11'h20, 16'h3, 32'h0, 4'h3, 32'h55, 4'h4, 32'h55);
        issue(4'h6, 11'h20, 16'h0, 32'h0, 4'h4, 32'h1_0000, 4'h5, 32'h1_0000);
        issue(4'h9, 11'h20, 16'h0, 32'h0, 4'h3, 32'h0, 4'h6, 32'h4);
    endtask
    task automatic t_errors;
        issue(4'h1, 11'h9, 16'h0, 32'h0, 4'h0, 32'h0, 4'h7, 32'h0);
        issue(4'h4, 11'h9, 16'h0, 32'h0, 4'h1, 32'h0, 4'h7, 32'h12);
        issue(4'h6, 11'h9, 16'h0, 32'h0, 4'h1, 32'h0, 4'h7, 32'h4);
        issue(4'h6, 11'h9, 16'h4, 32'h0, 4'h3, 32'h0, 4'h7, 32'h3);
        issue(4'h1, 11'h9, 16'h0, 32'h0, 4'h3, 32'h0, 4'h7, 32'h3);
        issue(4'h2, 11'h9, 16'h0, 32'h1, 4'h2, 32'h0, 4'h7, 32'h5);
        par_ok <= 1'b0;
        par_err <= 32'h11;
        issue(4'h3, 11'h9, 16'h0, 32'h1, 4'h2, 32'h0, 4'h7, 32'h11);
        par_ok <= 1'b1;
    endtask
    initial begin
        #100000;
        fail_count++;
        results();
    end
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        cmd_go = 1'b0;
        cmd_code = 4'h0;
        cmd_pnum = 11'h0;
        cmd_sub = 16'h0;
        cmd_value = 32'h0;
        par_kind = 4'h0;
        par_count = 16'h4;
        par_rdata = 32'h0;
        par_ok = 1'b1;
        par_err = 32'h0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        t_reads();
        t_writes();
        t_arrays();
        t_errors();
        t_freeze();
        results();
    end
endmodule
